//--- hw/ddc_front_pkg.sv
// Shared constants and carrier types for the downconverter front end
package ddc_front_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ_HOLD = 8'h04;
    localparam logic [7:0] OFS_FREQ_LOAD = 8'h08;
    localparam logic [7:0] OFS_PN_GAIN = 8'h0C;
    localparam logic [7:0] OFS_DEC_LEN = 8'h10;
    localparam logic [7:0] OFS_LVL_LEN = 8'h14;
    localparam logic [7:0] OFS_LVL_OUT = 8'h18;
    localparam logic [7:0] OFS_CIC_I = 8'h1C;
    localparam logic [7:0] OFS_CIC_Q = 8'h20;
    localparam logic [7:0] OFS_PHASE = 8'h24;
    // Reset values
    localparam logic [16:0] DEC_LEN_RST = 17'h0_0004;
    localparam logic [15:0] LVL_LEN_RST = 16'h0000;
    localparam logic [14:0] LFSR_A_SEED = 15'h0001;
    localparam logic [22:0] LFSR_B_SEED = 23'h00_0001;
    // Datapath widths and shifts
    localparam int SAMPLE_W = 24;
    localparam int TRIG_W = 19;
    localparam int PHASE_W = 24;
    localparam int COMB_W = 32;
    localparam int PN_LSB = 5;
    localparam int PN_Q_TAP = 7;
    localparam logic [5:0] BYPASS_SHIFT = 6'h2D;
    localparam logic [2:0] MAX_ORDER = 3'h5;
    localparam logic [18:0] TRIG_MAX = 19'h3_FFFF;
    // Leaky integrator shifts for A = 1, 2^-8, 2^-12, 2^-16
    localparam logic [4:0] LEAK_SH0 = 5'h00;
    localparam logic [4:0] LEAK_SH1 = 5'h08;
    localparam logic [4:0] LEAK_SH2 = 5'h0C;
    localparam logic [4:0] LEAK_SH3 = 5'h10;
    // Noise sequence choices
    localparam logic [1:0] PN_LEN_15 = 2'h0;
    localparam logic [1:0] PN_LEN_23 = 2'h1;

    // Complex slot sequencer states
    typedef enum logic [2:0] {
        SLOT_IDLE = 3'b001,
        SLOT_GAP = 3'b010,
        SLOT_Q = 3'b100
    } slot_t;

    // Control register layout, lsb is level_cont
    typedef struct packed {
        logic complex_en;
        logic q_late;
        logic sync_load_en;
        logic zero_phase;
        logic [2:0] cic_order;
        logic [5:0] cic_shift;
        logic [1:0] pn_len;
        logic leaky_en;
        logic [1:0] leak_sel;
        logic level_cont;
    } cfg_t;

    // One CIC path: five pruned integrators and five combs
    typedef struct packed {
        logic [68:0] int1;
        logic [61:0] int2;
        logic [52:0] int3;
        logic [43:0] int4;
        logic [33:0] int5;
        logic [4:0][31:0] comb_dly;
    } cic_chain_t;
endpackage

//--- hw/ddc_front_end.sv
// Downconverter front end: level detector, NCO mixer, noise and CIC
//
// Behaviour
// - Level detector: integrated magnitude or leaky integrator
// - Interval 2..65537, or continuous for the leaky integrator only; 32-bit accumulators
// - Q taken one or two clocks after I
// - I*cos, I*sin first; Q*-sin, Q*cos second
// - First integrator both cycles, rest first only
// - Complex mode: level uses I samples only
// - 32-bit frequency, 24-bit phase, 19-bit amplitude
// - Frequency double buffered; load by write or sync
// - Optional phase accumulator zeroing on frequency load
// - Noise chip scaled by 16-bit gain; zero disables
// - Noise sign bits aligned to signal MSBs
// - I/Q noise time-offset; lengths 15, 23, product
// - CIC order 0..5; order 0 bypasses
// - Integrators 69,62,53,44,34 bits; combs 32 bits
// - Sample low on 69-bit bus, 0..63 shift
`timescale 1ns/10ps
module ddc_front_end
    import ddc_front_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sample input from the converter
    input wire logic signed [ddc_front_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_strobe,
    input wire logic sync_input_pin,
    // Decimated CIC output and level detector output
    output logic signed [ddc_front_pkg::COMB_W-1:0] cic_i_out,
    output logic signed [ddc_front_pkg::COMB_W-1:0] cic_q_out,
    output logic cic_valid,
    output logic [31:0] level_out
);
    import ddc_front_pkg::*;

    typedef struct packed {
        cfg_t cfg;
        logic [31:0] freq_hold;
        logic [31:0] freq_act;
        logic [31:0] phase;
        logic [15:0] pn_gain;
        logic [16:0] dec_len;
        logic [15:0] lvl_len;
        logic [31:0] lvl_acc;
        logic [16:0] lvl_cnt;
        logic [31:0] lvl_out;
        logic [14:0] lfsr_a;
        logic [22:0] lfsr_b;
        slot_t slot;
        logic [23:0] mix_i;
        logic [23:0] mix_q;
        logic mix_en1;
        logic mix_enr;
        cic_chain_t cic_i;
        cic_chain_t cic_q;
        logic [16:0] dec_cnt;
        logic dump;
        logic [31:0] out_i;
        logic [31:0] out_q;
        logic out_valid;
        logic sync_q;
        logic [31:0] rdata;
        logic rerr;
    } state_t;

    state_t st_q;
    state_t st_d;

    // Parabolic sine: cheap, no table, spurs traded for area
    function automatic logic signed [TRIG_W-1:0] nco_sin(input logic [PHASE_W-1:0] p);
        logic [22:0] x;
        logic [46:0] prod;
        logic [18:0] mag;
        x = p[22:0];
        prod = {24'h00_0000, x} * ({24'h00_0000, ~x} + 47'h0000_0000_0001);
        mag = (prod[46:26] > {2'h0, TRIG_MAX}) ? TRIG_MAX : prod[44:26];
        return p[23] ? -signed'(mag) : signed'(mag);
    endfunction

    // Sample times trig, scaled back to 24 bits
    function automatic logic [23:0] mult(input logic signed [23:0] s,
                                         input logic signed [TRIG_W-1:0] c);
        logic signed [42:0] p;
        p = 43'(s) * 43'(c);
        return p[41:18];
    endfunction

    // Magnitude of a signed sample
    function automatic logic [31:0] mag32(input logic signed [23:0] s);
        logic [23:0] a;
        a = s[23] ? 24'(-s) : s;
        return {8'h00, a};
    endfunction

    // Integrator update: first stage gated apart from the rest
    function automatic cic_chain_t cic_integrate(input cic_chain_t c, input logic [68:0] in,
                                                 input logic en1, input logic enr);
        cic_chain_t n;
        n = c;
        if (en1)
        begin
            n.int1 = c.int1 + in;
        end
        if (enr)
        begin
            n.int2 = c.int2 + c.int1[68:7];
            n.int3 = c.int3 + c.int2[61:9];
            n.int4 = c.int4 + c.int3[52:9];
            n.int5 = c.int5 + c.int4[43:10];
        end
        return n;
    endfunction

    // Top 32 bits of the stage selected by order
    function automatic logic [31:0] cic_tap(input cic_chain_t c, input logic [2:0] order,
                                            input logic [68:0] in);
        logic [31:0] t;
        unique case (order)
            3'h0: t = in[68:37];
            3'h1: t = c.int1[68:37];
            3'h2: t = c.int2[61:30];
            3'h3: t = c.int3[52:21];
            3'h4: t = c.int4[43:12];
            default: t = c.int5[33:2];
        endcase
        return t;
    endfunction

    // Pre-CIC attenuator: sign-extend onto 69 bits, then shift
    function automatic logic [68:0] pre_shift(input logic signed [23:0] s, input logic [5:0] sh);
        logic signed [68:0] w;
        w = 69'(s);
        return w <<< sh;
    endfunction

    // Internal combinational values
    logic wr_en;
    logic rd_setup;
    logic freq_load;
    logic i_slot;
    logic q_slot;
    logic pn_chip_i;
    logic pn_chip_q;
    logic signed [23:0] pn_val_i;
    logic signed [23:0] pn_val_q;
    logic signed [TRIG_W-1:0] cos_v;
    logic signed [TRIG_W-1:0] sin_v;
    logic [68:0] sh_i;
    logic [68:0] sh_q;
    logic [2:0] order;
    logic [31:0] ci;
    logic [31:0] cq;
    logic [31:0] lvl_x;
    logic signed [32:0] leak_diff;
    logic [4:0] leak_sh;

    // APB decode; writes land in the access phase only
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign pready = psel & penable;
    assign prdata = st_q.rdata;
    assign pslverr = psel & penable & st_q.rerr;
    assign cic_i_out = st_q.out_i;
    assign cic_q_out = st_q.out_q;
    assign cic_valid = st_q.out_valid;
    assign level_out = st_q.lvl_out;

    always_comb
    begin
        st_d = st_q;
        st_d.out_valid = 1'b0;
        st_d.sync_q = sync_input_pin;

        // Read data captured in setup so the access phase has no wait state
        if (rd_setup)
        begin
            st_d.rerr = 1'b0;
            st_d.rdata = 32'h0000_0000;
            unique case (paddr[7:0])
                OFS_CTRL: st_d.rdata = 32'(st_q.cfg);
                OFS_FREQ_HOLD: st_d.rdata = st_q.freq_hold;
                OFS_FREQ_LOAD: st_d.rdata = st_q.freq_act;
                OFS_PN_GAIN: st_d.rdata = {16'h0000, st_q.pn_gain};
                OFS_DEC_LEN: st_d.rdata = {15'h0000, st_q.dec_len};
                OFS_LVL_LEN: st_d.rdata = {16'h0000, st_q.lvl_len};
                OFS_LVL_OUT: st_d.rdata = st_q.lvl_out;
                OFS_CIC_I: st_d.rdata = st_q.out_i;
                OFS_CIC_Q: st_d.rdata = st_q.out_q;
                OFS_PHASE: st_d.rdata = st_q.phase;
                default: st_d.rerr = 1'b1;
            endcase
        end

        // Register writes
        if (wr_en)
        begin
            unique case (paddr[7:0])
                OFS_CTRL: st_d.cfg = pwdata[$bits(cfg_t)-1:0];
                OFS_FREQ_HOLD: st_d.freq_hold = pwdata;
                OFS_PN_GAIN: st_d.pn_gain = pwdata[15:0];
                OFS_DEC_LEN: st_d.dec_len = pwdata[16:0];
                OFS_LVL_LEN: st_d.lvl_len = pwdata[15:0];
                default: ;
            endcase
        end

        // Complex slot sequencer; Q gap set by q_late
        i_slot = sample_valid_strobe;
        q_slot = 1'b0;
        unique case (st_q.slot)
            SLOT_IDLE:
            begin
                if (sample_valid_strobe && st_q.cfg.complex_en)
                begin
                    st_d.slot = st_q.cfg.q_late ? SLOT_GAP : SLOT_Q;
                end
            end
            SLOT_GAP:
            begin
                st_d.slot = SLOT_Q;
            end
            SLOT_Q:
            begin
                q_slot = 1'b1;
                i_slot = 1'b0;
                st_d.slot = SLOT_IDLE;
            end
        endcase

        // Active frequency loads from write or enabled sync edge
        freq_load = (wr_en && paddr[7:0] == OFS_FREQ_LOAD)
            || (st_q.cfg.sync_load_en && sync_input_pin && !st_q.sync_q);
        if (freq_load)
        begin
            st_d.freq_act = st_q.freq_hold;
        end

        // Phase steps once per sample; a complex pair steps after Q so I and Q share one phase
        cos_v = nco_sin(st_q.phase[31:8] + 24'h40_0000);
        sin_v = nco_sin(st_q.phase[31:8]);
        if (freq_load && st_q.cfg.zero_phase)
        begin
            st_d.phase = 32'h0000_0000;
        end
        else if (st_q.cfg.complex_en ? q_slot : i_slot)
        begin
            st_d.phase = st_q.phase + st_q.freq_act;
        end

        // Noise: Fibonacci LFSRs; Q uses a tap seven chips ahead of I to decorrelate
        unique case (st_q.cfg.pn_len)
            PN_LEN_15:
            begin
                pn_chip_i = st_q.lfsr_a[0];
                pn_chip_q = st_q.lfsr_a[PN_Q_TAP];
            end
            PN_LEN_23:
            begin
                pn_chip_i = st_q.lfsr_b[0];
                pn_chip_q = st_q.lfsr_b[PN_Q_TAP];
            end
            default:
            begin
                pn_chip_i = st_q.lfsr_a[0] ^ st_q.lfsr_b[0];
                pn_chip_q = st_q.lfsr_a[PN_Q_TAP] ^ st_q.lfsr_b[PN_Q_TAP];
            end
        endcase
        if (i_slot)
        begin
            st_d.lfsr_a = {st_q.lfsr_a[0] ^ st_q.lfsr_a[1], st_q.lfsr_a[14:1]};
            st_d.lfsr_b = {st_q.lfsr_b[0] ^ st_q.lfsr_b[5], st_q.lfsr_b[22:1]};
        end
        // Three sign bits over gain; zero gain adds nothing
        pn_val_i = 24'(signed'({1'b0, st_q.pn_gain}) * (pn_chip_i ? 17'sd1 : -17'sd1)) <<< PN_LSB;
        pn_val_q = 24'(signed'({1'b0, st_q.pn_gain}) * (pn_chip_q ? 17'sd1 : -17'sd1)) <<< PN_LSB;

        // Mixer, registered before the integrators
        st_d.mix_en1 = i_slot | q_slot;
        st_d.mix_enr = i_slot;
        if (i_slot)
        begin
            st_d.mix_i = mult(sample_in, cos_v) + pn_val_i;
            st_d.mix_q = mult(sample_in, sin_v) + pn_val_q;
        end
        else if (q_slot)
        begin
            st_d.mix_i = mult(sample_in, -sin_v);
            st_d.mix_q = mult(sample_in, cos_v);
        end

        // Integrators
        sh_i = pre_shift(st_q.mix_i, st_q.cfg.cic_shift);
        sh_q = pre_shift(st_q.mix_q, st_q.cfg.cic_shift);
        st_d.cic_i = cic_integrate(st_q.cic_i, sh_i, st_q.mix_en1, st_q.mix_enr);
        st_d.cic_q = cic_integrate(st_q.cic_q, sh_q, st_q.mix_en1, st_q.mix_enr);

        // Decimation counts every slot, so complex needs half as many pairs
        st_d.dump = 1'b0;
        if (st_q.mix_en1)
        begin
            if (st_q.dec_cnt + 17'h0_0001 >= st_q.dec_len)
            begin
                st_d.dec_cnt = 17'h0_0000;
                st_d.dump = 1'b1;
            end
            else
            begin
                st_d.dec_cnt = st_q.dec_cnt + 17'h0_0001;
            end
        end

        // Combs, run once per output over the active order
        order = (st_q.cfg.cic_order > MAX_ORDER) ? MAX_ORDER : st_q.cfg.cic_order;
        ci = cic_tap(st_q.cic_i, order, sh_i);
        cq = cic_tap(st_q.cic_q, order, sh_q);
        if (st_q.dump)
        begin
            for (int k = 0; k < 5; k++)
            begin
                if (3'(k) < order)
                begin
                    st_d.cic_i.comb_dly[k] = ci;
                    st_d.cic_q.comb_dly[k] = cq;
                    ci = ci - st_q.cic_i.comb_dly[k];
                    cq = cq - st_q.cic_q.comb_dly[k];
                end
            end
            st_d.out_i = ci;
            st_d.out_q = cq;
            st_d.out_valid = 1'b1;
        end

        // Level detector sees the strobed slot, never Q
        lvl_x = mag32(sample_in);
        unique case (st_q.cfg.leak_sel)
            2'h0: leak_sh = LEAK_SH0;
            2'h1: leak_sh = LEAK_SH1;
            2'h2: leak_sh = LEAK_SH2;
            default: leak_sh = LEAK_SH3;
        endcase
        leak_diff = signed'({1'b0, lvl_x}) - signed'({1'b0, st_q.lvl_acc});
        if (sample_valid_strobe)
        begin
            if (st_q.cfg.leaky_en)
            begin
                st_d.lvl_acc = 32'(signed'({1'b0, st_q.lvl_acc}) + (leak_diff >>> leak_sh));
            end
            else
            begin
                st_d.lvl_acc = st_q.lvl_acc + lvl_x;
            end
            if (st_q.cfg.leaky_en && st_q.cfg.level_cont)
            begin
                st_d.lvl_out = st_d.lvl_acc;
            end
            else if (st_q.lvl_cnt >= {1'b0, st_q.lvl_len} + 17'h0_0001)
            begin
                // Interval is lvl_len + 2 samples
                st_d.lvl_cnt = 17'h0_0000;
                st_d.lvl_out = st_d.lvl_acc;
                if (!st_q.cfg.leaky_en)
                begin
                    st_d.lvl_acc = 32'h0000_0000;
                end
            end
            else
            begin
                st_d.lvl_cnt = st_q.lvl_cnt + 17'h0_0001;
            end
        end
    end

    // State register; LFSRs must never seed to zero
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '0;
            st_q.slot <= SLOT_IDLE;
            st_q.dec_len <= DEC_LEN_RST;
            st_q.lvl_len <= LVL_LEN_RST;
            st_q.lfsr_a <= LFSR_A_SEED;
            st_q.lfsr_b <= LFSR_B_SEED;
        end
        else
        begin
            st_q <= st_d;
        end
    end
endmodule

//--- dv/ddc_front_chk.sv
// Port-level assertions for the downconverter front end
`timescale 1ns/10ps
module ddc_front_chk #(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Samples
    input wire logic signed [ddc_front_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_strobe,
    input wire logic sync_input_pin,
    // Results
    input wire logic signed [ddc_front_pkg::COMB_W-1:0] cic_i_out,
    input wire logic signed [ddc_front_pkg::COMB_W-1:0] cic_q_out,
    input wire logic cic_valid,
    input wire logic [31:0] level_out
);
    import ddc_front_pkg::*;
    logic setup_c;
    // Setup phase of an APB transfer
    assign setup_c = psel && !penable;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);

    chk_ready_zero: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    chk_err_access: assert property (pslverr |-> (psel && penable))
        else $error("pslverr outside access phase");
    chk_err_zero: assert property (pslverr |-> (prdata == 32'h0000_0000))
        else $error("refused read returned data");
    chk_rdata_stands: assert property (!$past(setup_c) |-> $stable(prdata))
        else $error("prdata moved outside a setup edge");
    // Strobe of a real or complex input is 3 to 5 edges back
    chk_valid_cause: assert property (cic_valid |->
        ($past(sample_valid_strobe, 3) || $past(sample_valid_strobe, 4) || $past(sample_valid_strobe, 5)))
        else $error("cic_valid without a sample behind it");
    chk_out_hold: assert property (!cic_valid |-> ($stable(cic_i_out) && $stable(cic_q_out)))
        else $error("CIC output moved without cic_valid");
    chk_level_cause: assert property ($changed(level_out) |-> $past(sample_valid_strobe))
        else $error("level_out moved without a sample");
    // Reset must hold cic_valid, level_out and pslverr at zero
    chk_reset_quiet: assert property (disable iff (1'b0)
        reset |-> (!cic_valid && level_out == 32'h0000_0000 && !pslverr))
        else $error("outputs active during reset");

    cover property (cic_valid);
    cover property (pslverr);
    cover property ($changed(level_out));
endmodule

//--- dv/adc_source_model.sv
// Converter model driving the parallel sample bus
`timescale 1ns/10ps
module adc_source_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Requests from the bench
    input wire logic go,
    input wire logic cplx,
    input wire logic q_late,
    input wire logic [23:0] i_val,
    input wire logic [23:0] q_val,
    // Sample bus
    output logic signed [23:0] sample_in,
    output logic sample_valid_strobe,
    output logic busy
);
    logic [1:0] gap_q;
    // Busy until the Q slot has been presented
    assign busy = sample_valid_strobe || (gap_q != 2'h0);
    // I with strobe, Q after one or two slots; idle slots toggle so a wrong capture shows
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sample_in <= '0;
            sample_valid_strobe <= 1'b0;
            gap_q <= 2'h0;
        end
        else if (go)
        begin
            sample_in <= i_val;
            sample_valid_strobe <= 1'b1;
            gap_q <= cplx ? (q_late ? 2'h2 : 2'h1) : 2'h0;
        end
        else
        begin
            sample_valid_strobe <= 1'b0;
            sample_in <= (gap_q == 2'h1) ? q_val : ~sample_in;
            if (gap_q != 2'h0)
                gap_q <= gap_q - 2'h1;
        end
    end
endmodule

//--- dv/tb.sv
// Self-checking bench for the downconverter front end
`timescale 1ns/10ps
module tb;
    import ddc_front_pkg::*;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, sync_input_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, level_out, rd, p0;
    logic signed [23:0] sample_in;
    logic signed [31:0] cic_i_out, cic_q_out;
    logic sample_valid_strobe, cic_valid, go, cplx, ql, busy, err;
    logic [23:0] i_val, q_val;
    int fail_count = 0;
    int comparisons = 0;
    int n_valid = 0;
    int base;

    // Clock, 100 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    ddc_front_end #(.ADDR_W(8)) i_dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sample_in, .sample_valid_strobe, .sync_input_pin, .cic_i_out,
        .cic_q_out, .cic_valid, .level_out);
    adc_source_model i_adc (.core_clk, .reset, .go, .cplx, .q_late(ql), .i_val, .q_val, .sample_in,
        .sample_valid_strobe, .busy);

    // Count decimated outputs
    always @(posedge core_clk)
        if (cic_valid === 1'b1)
            n_valid++;

    task give_verdict;
        if (fail_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready with a bound
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        if (k >= 16)
            fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // One real sample or complex pair, then room for the pipeline
    task send(input logic [23:0] i, input logic [23:0] q, input logic c);
        int k;
        @(posedge core_clk);
        go <= 1'b1;
        i_val <= i;
        q_val <= q;
        cplx <= c;
        @(posedge core_clk);
        go <= 1'b0;
        k = 0;
        while (busy && k < 8)
        begin
            @(posedge core_clk);
            k++;
        end
        repeat (8) @(posedge core_clk);
    endtask

    // Hang guard, far beyond the expected run
    initial
    begin
        #3_000_000;
        fail_count++;
        give_verdict;
    end

    initial
    begin
        // Nonblocking so the reset edge at time 0 reaches the design
        reset <= 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sync_input_pin = 1'b0;
        go = 1'b0;
        cplx = 1'b0;
        ql = 1'b0;
        i_val = 24'h00_0000;
        q_val = 24'h00_0000;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rdc(OFS_CTRL, 32'h0000_0000);
        rdc(OFS_DEC_LEN, 32'(DEC_LEN_RST));
        rdc(OFS_LVL_LEN, 32'h0000_0000);
        apb(1'b0, 8'h28, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        wr(OFS_CTRL, 32'hFFFF_FFFF);
        rdc(OFS_CTRL, 32'h0007_FFFF);
        // Integrated magnitude over three samples
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_LVL_LEN, 32'h0000_0001);
        send(-24'sd5, 0, 1'b0);
        send(24'sd7, 0, 1'b0);
        send(24'sd10, 0, 1'b0);
        chk(level_out, 32'h0000_0016);
        rdc(OFS_LVL_OUT, 32'h0000_0016);
        // Complex input: Q must not reach the level
        wr(OFS_LVL_LEN, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0004_0000);
        send(24'sd100, 24'sd5000, 1'b1);
        send(-24'sd50, 24'sd7000, 1'b1);
        chk(level_out, 32'h0000_0096);
        // Leaky integrator, A of one then 2^-8
        wr(OFS_CTRL, 32'h0000_0009);
        send(-24'sd300, 0, 1'b0);
        chk(level_out, 32'h0000_012C);
        wr(OFS_CTRL, 32'h0000_000B);
        send(24'sd1324, 0, 1'b0);
        chk(level_out, 32'h0000_0130);
        // Double-buffered frequency and phase stepping
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_FREQ_HOLD, 32'hC000_0000);
        rdc(OFS_FREQ_LOAD, 32'h0000_0000);
        wr(OFS_FREQ_LOAD, 32'h0000_0000);
        rdc(OFS_FREQ_LOAD, 32'hC000_0000);
        apb(1'b0, OFS_PHASE, 32'h0000_0000);
        p0 = rd;
        repeat (3) send(24'sd1, 0, 1'b0);
        apb(1'b0, OFS_PHASE, 32'h0000_0000);
        chk(rd - p0, 32'h4000_0000);
        wr(OFS_CTRL, 32'h0000_8000);
        wr(OFS_FREQ_LOAD, 32'h0000_0000);
        rdc(OFS_PHASE, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0001_8000);
        wr(OFS_FREQ_HOLD, 32'h0000_1234);
        @(posedge core_clk);
        sync_input_pin <= 1'b1;
        repeat (2) @(posedge core_clk);
        sync_input_pin <= 1'b0;
        rdc(OFS_FREQ_LOAD, 32'h0000_1234);
        // Fresh start for the CIC: second reset mid-run
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0B40);
        wr(OFS_DEC_LEN, 32'h0000_0001);
        base = n_valid;
        send(24'h10_0000, 0, 1'b0);
        chk(32'(n_valid - base), 32'h0000_0001);
        chk(cic_q_out, 32'h0000_0000);
        chk(32'(cic_i_out > 0), 32'h0000_0001);
        send(24'h00_0000, 0, 1'b0);
        chk(cic_i_out, 32'h0000_0000);
        wr(OFS_PN_GAIN, 32'h0000_7FFF);
        send(24'h00_0000, 0, 1'b0);
        chk(32'(cic_i_out != 0), 32'h0000_0001);
        wr(OFS_PN_GAIN, 32'h0000_0000);
        wr(OFS_DEC_LEN, 32'h0000_0004);
        base = n_valid;
        repeat (4) send(24'h10_0000, 0, 1'b0);
        chk(32'(n_valid - base), 32'h0000_0001);
        // Complex pair with Q one or two clocks after I
        wr(OFS_DEC_LEN, 32'h0000_0002);
        for (int s = 0; s < 2; s++)
        begin
            ql <= s[0];
            wr(OFS_CTRL, 32'h0004_0B40 | (32'(s) << 17));
            base = n_valid;
            send(24'h00_0000, 24'h10_0000, 1'b1);
            chk(32'(n_valid - base), 32'h0000_0001);
            chk(cic_i_out, 32'h0000_0000);
            chk(32'(cic_q_out > 0), 32'h0000_0001);
        end
        give_verdict;
    end
endmodule

bind ddc_front_end ddc_front_chk #(.ADDR_W(ADDR_W)) u_chk (.core_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_in, .sample_valid_strobe, .sync_input_pin,
    .cic_i_out, .cic_q_out, .cic_valid, .level_out);
